// >>> hdl/cdisc_power_ctrl.sv
// Power-mode controller: sleep/idle, doze throttle, regulator mode, Wishbone registers.
// Assumes CPU, interrupt logic and watchdog on the same clock; their strobes are pulses.
`timescale 1ns/1ps
`default_nettype none
module cdisc_power_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_bor_i, // Reset cause is power-on or brown-out
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU and interrupt side
    input wire logic sleep_instr_i, // Sleep instruction executed
    input wire logic irq_pending_i, // Enabled interrupt pending
    input wire logic irq_entry_i, // Service routine entry
    input wire logic irq_return_instr_i,
    input wire logic watchdog_timeout_i,
    input wire logic in_circuit_debug_i,
    input wire logic clock_output_pin_en_i,
    output logic cpu_clk_en_o, // CPU executes this cycle
    output logic program_flash_en_o,
    output logic periph_sysclk_en_o,
    output logic clock_output_pin_en_o,
    output logic core_regulator_lp_o,
    output logic watchdog_clear_o,
    output logic watchdog_reset_block_o,
    output logic powerdown_flag_clr_o,
    output logic timeout_flag_set_o,
    output logic [3:0] power_state_o
);
    import cdisc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic regulator_low_power_sel_q;
    logic idle_on_sleep_en_q;
    logic cpu_throttle_en_q;
    logic recover_on_irq_q;
    logic throttle_on_irq_return_q;
    logic [CDISC_DOZE_RATIO_W-1:0] ratio_q;
    cdisc_state_t state_q;
    logic [CDISC_CNT_W-1:0] wake_cnt_q;
    logic wr_regctl;
    logic wr_doze;
    logic acc;
    logic tick;
    logic full_speed;

    // Access decode; byte lane 0 carries the 8-bit registers
    always_comb begin
        acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr_regctl = acc && wb_we_i && wb_sel_i[0] && wb_adr_i == CDISC_REG_REGCTL_OFF;
        wr_doze = acc && wb_we_i && wb_sel_i[0] && wb_adr_i == CDISC_REG_DOZE_OFF;
    end

    // Ack one cycle after request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    // Read data; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (acc && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == CDISC_REG_REGCTL_OFF) begin
                // Upper bits zero, reserved bit reads one
                wb_dat_o[CDISC_REGCTL_LP_BIT] <= regulator_low_power_sel_q;
                wb_dat_o[CDISC_REGCTL_RSV_BIT] <= 1'b1;
            end else if (wb_adr_i == CDISC_REG_DOZE_OFF) begin
                // Bit 3 reads zero
                wb_dat_o[CDISC_DOZE_IDLE_BIT] <= idle_on_sleep_en_q;
                wb_dat_o[CDISC_DOZE_EN_BIT] <= cpu_throttle_en_q;
                wb_dat_o[CDISC_DOZE_ROI_BIT] <= recover_on_irq_q;
                wb_dat_o[CDISC_DOZE_DOE_BIT] <= throttle_on_irq_return_q;
                wb_dat_o[CDISC_DOZE_RATIO_W-1:0] <= ratio_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulator_low_power_sel_q <= CDISC_REGCTL_RST[CDISC_REGCTL_LP_BIT];
        end else if (wr_regctl) begin
            regulator_low_power_sel_q <= wb_dat_i[CDISC_REGCTL_LP_BIT];
        end
    end

    // Idle enable keeps value on other resets
    always_ff @(posedge clk_i) begin
        if (rst_i && por_bor_i) begin
            idle_on_sleep_en_q <= CDISC_DOZE_RST[CDISC_DOZE_IDLE_BIT];
        end else if (!rst_i && wr_doze) begin
            idle_on_sleep_en_q <= wb_dat_i[CDISC_DOZE_IDLE_BIT];
        end
    end

    // Other doze fields clear on every reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            recover_on_irq_q <= CDISC_DOZE_RST[CDISC_DOZE_ROI_BIT];
            throttle_on_irq_return_q <= CDISC_DOZE_RST[CDISC_DOZE_DOE_BIT];
            ratio_q <= CDISC_DOZE_RST[CDISC_DOZE_RATIO_W-1:0];
        end else if (wr_doze) begin
            recover_on_irq_q <= wb_dat_i[CDISC_DOZE_ROI_BIT];
            throttle_on_irq_return_q <= wb_dat_i[CDISC_DOZE_DOE_BIT];
            ratio_q <= wb_dat_i[CDISC_DOZE_RATIO_W-1:0];
        end
    end

    // Throttle enable: hardware entry/return beat software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_throttle_en_q <= CDISC_DOZE_RST[CDISC_DOZE_EN_BIT];
        end else if (irq_entry_i && recover_on_irq_q) begin
            cpu_throttle_en_q <= 1'b0;
        end else if (irq_return_instr_i && throttle_on_irq_return_q) begin
            cpu_throttle_en_q <= 1'b1;
        end else if (state_q == CDISC_IDLE && irq_pending_i && recover_on_irq_q) begin
            cpu_throttle_en_q <= 1'b0;
        end else if (wr_doze) begin
            cpu_throttle_en_q <= wb_dat_i[CDISC_DOZE_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CDISC_RUN;
            wake_cnt_q <= '0;
        end else begin
            unique case (state_q)
                CDISC_RUN: begin
                    // Pending interrupt makes sleep a no-op
                    if (sleep_instr_i && !irq_pending_i) begin
                        state_q <= idle_on_sleep_en_q ? CDISC_IDLE : CDISC_SLEEP;
                    end
                end
                CDISC_IDLE: begin
                    // Interrupt or watchdog ends idle; idle enable untouched
                    if (irq_pending_i || watchdog_timeout_i) begin
                        state_q <= CDISC_RUN;
                    end
                end
                CDISC_SLEEP: begin
                    if (irq_pending_i || watchdog_timeout_i) begin
                        if (regulator_low_power_sel_q) begin
                            state_q <= CDISC_WAKE;
                            wake_cnt_q <= CDISC_CNT_W'(CDISC_WAKE_LP_CYC - 1);
                        end else begin
                            state_q <= CDISC_RUN;
                        end
                    end
                end
                CDISC_WAKE: begin
                    // Regulator stabilisation
                    if (wake_cnt_q == '0) begin
                        state_q <= CDISC_RUN;
                    end else begin
                        wake_cnt_q <= wake_cnt_q - CDISC_CNT_W'(1);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Throttle divider
    always_comb begin
        full_speed = in_circuit_debug_i || !cpu_throttle_en_q;
    end

    cdisc_ratio_gen u_ratio (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ratio_i(ratio_q),
        .throttle_i(!full_speed),
        .cpu_tick_o(tick)
    );

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o <= 1'b0;
            program_flash_en_o <= 1'b0;
            periph_sysclk_en_o <= 1'b1;
            clock_output_pin_en_o <= 1'b0;
            core_regulator_lp_o <= 1'b0;
            watchdog_clear_o <= 1'b0;
            watchdog_reset_block_o <= 1'b0;
            powerdown_flag_clr_o <= 1'b0;
            timeout_flag_set_o <= 1'b0;
            power_state_o <= 4'h1;
        end else begin
            cpu_clk_en_o <= (state_q == CDISC_RUN) && tick;
            program_flash_en_o <= (state_q == CDISC_RUN) && tick;
            periph_sysclk_en_o <= (state_q != CDISC_SLEEP) && (state_q != CDISC_WAKE);
            clock_output_pin_en_o <= clock_output_pin_en_i
                && (state_q == CDISC_RUN || state_q == CDISC_IDLE);
            core_regulator_lp_o <= (state_q == CDISC_SLEEP) && regulator_low_power_sel_q;
            watchdog_reset_block_o <= (state_q == CDISC_IDLE);
            // Sleep entry pulses
            watchdog_clear_o <= (state_q == CDISC_RUN && sleep_instr_i && !irq_pending_i
                && !idle_on_sleep_en_q);
            powerdown_flag_clr_o <= (state_q == CDISC_RUN && sleep_instr_i && !irq_pending_i
                && !idle_on_sleep_en_q);
            timeout_flag_set_o <= (state_q == CDISC_RUN && sleep_instr_i && !irq_pending_i
                && !idle_on_sleep_en_q);
            power_state_o <= state_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_idle_entry;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_RUN && sleep_instr_i && !irq_pending_i && idle_on_sleep_en_q)
            |=> state_q == CDISC_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
    property p_idle_halt;
        @(posedge clk_i) disable iff (rst_i)
        state_q == CDISC_IDLE |=> !cpu_clk_en_o && !program_flash_en_o && periph_sysclk_en_o;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("idle not halting CPU");
    property p_sleep_periph;
        @(posedge clk_i) disable iff (rst_i)
        state_q == CDISC_SLEEP |=> !periph_sysclk_en_o;
    endproperty
    a_sleep_periph: assert property (p_sleep_periph) else $error("periph run in sleep");
    property p_irq_idle;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_IDLE && irq_pending_i) |=> state_q == CDISC_RUN && $stable(idle_on_sleep_en_q);
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq did not end idle");
    property p_wdt_idle;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_IDLE && watchdog_timeout_i && !irq_pending_i && !wr_doze
            && !irq_entry_i && !irq_return_instr_i) |=> $stable(cpu_throttle_en_q);
    endproperty
    a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog changed throttle");
    property p_roi;
        @(posedge clk_i) disable iff (rst_i)
        (irq_entry_i && recover_on_irq_q) |=> !cpu_throttle_en_q;
    endproperty
    a_roi: assert property (p_roi) else $error("recover did not clear throttle");
    property p_doe;
        @(posedge clk_i) disable iff (rst_i)
        (irq_return_instr_i && throttle_on_irq_return_q && !irq_entry_i) |=> cpu_throttle_en_q;
    endproperty
    a_doe: assert property (p_doe) else $error("return did not set throttle");
    property p_lp_wake;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_SLEEP && irq_pending_i && regulator_low_power_sel_q)
            |=> state_q == CDISC_WAKE ##1 state_q == CDISC_WAKE;
    endproperty
    a_lp_wake: assert property (p_lp_wake) else $error("no wake delay");
    property p_debug;
        @(posedge clk_i) disable iff (rst_i)
        (in_circuit_debug_i && state_q == CDISC_RUN) |=> cpu_clk_en_o;
    endproperty
    a_debug: assert property (p_debug) else $error("debug not full speed");
    // Pending interrupt turns sleep into a no-op
    property p_nop_sleep;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_RUN && irq_pending_i) |=> state_q == CDISC_RUN && !watchdog_clear_o;
    endproperty
    a_nop_sleep: assert property (p_nop_sleep) else $error("sleep with irq pending");
    property p_sleep_flags;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_RUN && sleep_instr_i && !irq_pending_i && !idle_on_sleep_en_q)
            |=> watchdog_clear_o && powerdown_flag_clr_o && timeout_flag_set_o;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags missing");
    property p_clock_output_pin_idle;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_IDLE && clock_output_pin_en_i) |=> clock_output_pin_en_o;
    endproperty
    a_clock_output_pin_idle: assert property (p_clock_output_pin_idle) else $error("clock output stopped");
    property p_wdt_wake;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_IDLE && watchdog_timeout_i)
            |=> state_q == CDISC_RUN && watchdog_reset_block_o;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog did not wake");
    property p_full_speed;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_RUN && !cpu_throttle_en_q) |=> cpu_clk_en_o && program_flash_en_o;
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("throttle off yet slowed");
    property p_fast_wake;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == CDISC_SLEEP && irq_pending_i && !regulator_low_power_sel_q)
            |=> state_q == CDISC_RUN;
    endproperty
    a_fast_wake: assert property (p_fast_wake) else $error("slow wake in normal mode");
endmodule
`default_nettype wire

// >>> pkg/cdisc_pkg.sv
// Constants, field layouts and state codes of the doze, idle and sleep controller.
// Assumes a 50 MHz system clock and a classic Wishbone register bus.
package cdisc_pkg;
    // Register byte offsets
    localparam logic [3:0] CDISC_REG_REGCTL_OFF = 4'h0;
    localparam logic [3:0] CDISC_REG_DOZE_OFF = 4'h4;
    // Regulator control fields
    localparam int CDISC_REGCTL_LP_BIT = 1;
    localparam int CDISC_REGCTL_RSV_BIT = 0;
    localparam logic [7:0] CDISC_REGCTL_RST = 8'h01;
    // Doze control fields
    localparam int CDISC_DOZE_IDLE_BIT = 7;
    localparam int CDISC_DOZE_EN_BIT = 6;
    localparam int CDISC_DOZE_ROI_BIT = 5;
    localparam int CDISC_DOZE_DOE_BIT = 4;
    localparam int CDISC_DOZE_RATIO_LSB = 0;
    localparam int CDISC_DOZE_RATIO_W = 3;
    localparam logic [7:0] CDISC_DOZE_WMASK = 8'hF7;
    localparam logic [7:0] CDISC_DOZE_RST = 8'h00;
    // Wake delays
    localparam int CDISC_CLK_MHZ = 50;
    localparam int CDISC_WAKE_LP_US = 10;
    localparam int CDISC_WAKE_LP_CYC = CDISC_WAKE_LP_US * CDISC_CLK_MHZ;
    localparam int CDISC_CNT_W = 9;
    // Power states
    typedef enum logic [3:0] {
        CDISC_RUN = 4'b0001,
        CDISC_IDLE = 4'b0010,
        CDISC_SLEEP = 4'b0100,
        CDISC_WAKE = 4'b1000
    } cdisc_state_t;
endpackage

// >>> hdl/cdisc_ratio_gen.sv
// Doze ratio divider: one-cycle CPU enable once per selected period.
// Assumes the same clock as the main controller.
`timescale 1ns/1ps
`default_nettype none
module cdisc_ratio_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [cdisc_pkg::CDISC_DOZE_RATIO_W-1:0] ratio_i,
    input wire logic throttle_i,
    output logic cpu_tick_o
);
    import cdisc_pkg::*;
    logic [7:0] cnt_q; // Period position
    logic [7:0] last; // Last count of period

    // Period length minus one, 2^(code+1)-1; four-bit shift count so code seven reaches 256
    always_comb begin
        last = 8'(({1'b0, 8'h01} << ({1'b0, ratio_i} + 4'd1)) - 9'h001);
    end

    // Count through period; restart when throttle is off
    always_ff @(posedge clk_i) begin
        if (rst_i || !throttle_i || cnt_q >= last) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // One active cycle, rest idle
    always_comb begin
        cpu_tick_o = !throttle_i || (cnt_q == 8'h00);
    end

    // Three throttled cycles at the 1:4 ratio
    sequence s_quarter_hold;
        (throttle_i && ratio_i == 3'd1) [*3];
    endsequence
    property p_period;
        @(posedge clk_i) disable iff (rst_i)
        (throttle_i && ratio_i == 3'd1 && cpu_tick_o) ##1 s_quarter_hold
            |-> !cpu_tick_o && !$past(cpu_tick_o) && !$past(cpu_tick_o, 2);
    endproperty
    a_period: assert property (p_period) else $error("ratio 1:4 tick too soon");
    property p_ratio2;
        @(posedge clk_i) disable iff (rst_i)
        (throttle_i && ratio_i == 3'd0 && cpu_tick_o) ##1 throttle_i |-> !cpu_tick_o;
    endproperty
    a_ratio2: assert property (p_ratio2) else $error("ratio 1:2 tick twice");
endmodule
`default_nettype wire

// >>> verification/cdisc_cpu_model.sv
// Stand-in for the CPU core, interrupt logic and watchdog around the power controller.
// Assumes the bench raises one command bit for a single cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module cdisc_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] cmd_i, // Sleep, irq, clear, return, watchdog
    input wire logic global_irq_en_i,
    input wire logic cpu_clk_en_i,
    output logic sleep_instr_o,
    output logic irq_pending_o,
    output logic irq_entry_o,
    output logic irq_return_instr_o,
    output logic watchdog_timeout_o
);
    ////////////////////////////////////////////////////////////////
    // Instruction and time-out strobes, one cycle each
    always_ff @(posedge clk_i) begin
        sleep_instr_o <= !rst_i && cmd_i[0];
        irq_return_instr_o <= !rst_i && cmd_i[3];
        watchdog_timeout_o <= !rst_i && cmd_i[4];
    end
    // Pending flag holds until serviced or cleared by software
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_i[2] || irq_entry_o) begin
            irq_pending_o <= 1'b0;
        end else if (cmd_i[1]) begin
            irq_pending_o <= 1'b1;
        end
    end
    // Vector taken only on an executing cycle with interrupts enabled
    always_ff @(posedge clk_i) begin
        irq_entry_o <= !rst_i && irq_pending_o && global_irq_en_i && cpu_clk_en_i && !irq_entry_o;
    end
endmodule
`default_nettype wire

// >>> verification/cdisc_power_ctrl_tb_top.sv
// Self-checking bench of the doze, idle and sleep power controller.
// Assumes the CPU stand-in model, a 50 MHz clock and Wishbone byte lane 0.
`timescale 1ns/1ps
`default_nettype none
module cdisc_power_ctrl_tb_top;
    import cdisc_pkg::*;
    logic clk_i, rst_i, por_bor, cyc, stb, we, ack, dbg, clock_output_pin, global_irq_en;
    logic cpu_en, flash_en, per_en, clock_output_pin_o, reg_lp, wclr, wblk, pdclr, toset;
    logic sl, pend, ent, ret, wdt;
    logic [3:0] adr, state, lane, sel;
    logic [31:0] wdat, rdat;
    logic [4:0] cmd;
    logic [31:0] q;
    int miscompares, cmp_count, cyc_cnt, n_wclr, n_pd, n_to, cnt;
    ////////////////////////////////////////////////////////////////
    cdisc_power_ctrl cdisc_power_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .por_bor_i(por_bor),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_instr_i(sl),
        .irq_pending_i(pend), .irq_entry_i(ent), .irq_return_instr_i(ret),
        .watchdog_timeout_i(wdt), .in_circuit_debug_i(dbg), .clock_output_pin_en_i(clock_output_pin),
        .cpu_clk_en_o(cpu_en), .program_flash_en_o(flash_en), .periph_sysclk_en_o(per_en),
        .clock_output_pin_en_o(clock_output_pin_o), .core_regulator_lp_o(reg_lp),
        .watchdog_clear_o(wclr), .watchdog_reset_block_o(wblk),
        .powerdown_flag_clr_o(pdclr), .timeout_flag_set_o(toset), .power_state_o(state));
    cdisc_cpu_model cdisc_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd),
        .global_irq_en_i(global_irq_en), .cpu_clk_en_i(cpu_en), .sleep_instr_o(sl),
        .irq_pending_o(pend), .irq_entry_o(ent), .irq_return_instr_o(ret),
        .watchdog_timeout_o(wdt));
    ////////////////////////////////////////////////////////////////
    // Free-running 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Pulse tallies and hang guard
    always @(posedge clk_i) begin
        cyc_cnt++;
        n_wclr += int'(wclr);
        n_pd += int'(pdclr);
        n_to += int'(toset);
        if (cyc_cnt == 20000) begin
            miscompares++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lane;
        wdat <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask
    // One-cycle command to the CPU model, then settle
    task automatic send(input logic [4:0] c);
        @(posedge clk_i);
        cmd <= c;
        @(posedge clk_i);
        cmd <= 5'h00;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic count(input int len);
        cnt = 0;
        repeat (len) begin
            @(posedge clk_i);
            cnt += int'(cpu_en);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(4'h0, 8'h01);
        rd(4'h4, 8'h00);
        wb(1'b1, 4'h0, 8'hFF);
        rd(4'h0, 8'h03);
        wb(1'b1, 4'h4, 8'hFF);
        rd(4'h4, 8'hF7);
        wb(1'b1, 4'h8, 8'hFF);
        rd(4'h8, 8'h00);
        wb(1'b1, 4'h0, 8'h01);
        // Write without byte lane 0 is ignored
        lane = 4'h2;
        wb(1'b1, 4'h0, 8'hFF);
        lane = 4'h1;
        rd(4'h0, 8'h01);
    endtask
    // Every ratio code over two full 1:256 windows
    task automatic t_ratio;
        for (int n = 0; n < 8; n++) begin
            wb(1'b1, 4'h4, 8'h40 | 8'(n));
            repeat (8) @(posedge clk_i);
            count(512);
            chk(cnt, 512 >> (n + 1));
            chk(per_en, 1'b1);
        end
        wb(1'b1, 4'h4, 8'h07);
        count(64);
        chk(cnt, 64);
    endtask
    task automatic t_debug;
        wb(1'b1, 4'h4, 8'h47);
        dbg <= 1'b1;
        repeat (4) @(posedge clk_i);
        count(32);
        chk(cnt, 32);
        dbg <= 1'b0;
        rd(4'h4, 8'h47);
    endtask
    task automatic t_irq;
        global_irq_en <= 1'b1;
        wb(1'b1, 4'h4, 8'h70);
        send(5'h02);
        rd(4'h4, 8'h30);
        count(16);
        chk(cnt, 16);
        send(5'h08);
        rd(4'h4, 8'h70);
        wb(1'b1, 4'h4, 8'h40);
        send(5'h02);
        rd(4'h4, 8'h40);
        wb(1'b1, 4'h4, 8'h00);
        send(5'h08);
        rd(4'h4, 8'h00);
        global_irq_en <= 1'b0;
    endtask
    task automatic t_sleep;
        n_wclr = 0;
        n_pd = 0;
        n_to = 0;
        send(5'h01);
        chk(state, CDISC_SLEEP);
        chk(per_en, 1'b0);
        chk({cpu_en, n_wclr[1:0], n_pd[1:0], n_to[1:0]}, 7'h15);
        send(5'h02);
        chk({state, cpu_en, flash_en}, {CDISC_RUN, 2'b11});
        send(5'h04);
    endtask
    task automatic t_idle;
        clock_output_pin <= 1'b1;
        n_wclr = 0;
        wb(1'b1, 4'h4, 8'h80);
        send(5'h01);
        chk(state, CDISC_IDLE);
        chk({cpu_en, flash_en, per_en, n_wclr[0]}, 4'h2);
        chk({clock_output_pin_o, wblk}, 2'b11);
        send(5'h02);
        chk(state, CDISC_RUN);
        rd(4'h4, 8'h80);
        send(5'h04);
        wb(1'b1, 4'h4, 8'hE0);
        send(5'h01);
        send(5'h02);
        rd(4'h4, 8'hA0);
        send(5'h04);
        wb(1'b1, 4'h4, 8'hE0);
        send(5'h01);
        send(5'h10);
        chk(state, CDISC_RUN);
        rd(4'h4, 8'hE0);
        wb(1'b1, 4'h4, 8'h00);
    endtask
    task automatic t_lp;
        wb(1'b1, 4'h0, 8'h03);
        send(5'h01);
        chk({state, reg_lp}, {CDISC_SLEEP, 1'b1});
        send(5'h02);
        repeat (CDISC_WAKE_LP_CYC - 30) @(posedge clk_i);
        chk({state, cpu_en}, {CDISC_WAKE, 1'b0});
        repeat (40) @(posedge clk_i);
        chk({state, reg_lp}, {CDISC_RUN, 1'b0});
        send(5'h04);
    endtask
    task automatic t_reset(input logic pb, input logic [7:0] e);
        wb(1'b1, 4'h4, 8'hF7);
        @(posedge clk_i);
        rst_i <= 1'b1;
        por_bor <= pb;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h4, e);
        rd(4'h0, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("Compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_i, por_bor, cyc, stb, we, dbg, clock_output_pin, global_irq_en} = 8'hC0;
        {adr, sel, wdat, cmd, miscompares, cmp_count, cyc_cnt} = '0;
        lane = 4'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_ratio();
        t_debug();
        t_irq();
        t_sleep();
        t_idle();
        t_lp();
        t_reset(1'b0, 8'h80);
        t_reset(1'b1, 8'h00);
        results();
    end
endmodule
`default_nettype wire
